// ---- audio_rate_defs.vh ----
// constants for the audio serial rate control block
// assumes a 50 MHz ref_clk; included by bare name
`ifndef AUDIO_RATE_DEFS_VH
`define AUDIO_RATE_DEFS_VH
// apb register byte offsets
`define REG_CTRL        8'h00
`define REG_WATER       8'h04
`define REG_PKT         8'h08
`define REG_STATUS      8'h0c
`define REG_SOF_AVG     8'h10
`define REG_RATE        8'h14
`define REG_FIFO        8'h18
// ctrl fields
`define CTRL_EN_BIT     0
`define CTRL_IN_MODE    2:1
`define CTRL_OUT_MODE   4:3
`define CTRL_RESET      32'h0000_000d
// mode codes
`define MODE_ASYNC      2'h0
`define MODE_SYNC       2'h1
`define MODE_ADAPT      2'h2
// water marks reset: low 8, high 24
`define WATER_RESET     32'h0018_0008
// packet sizes reset (words): low 47, nominal 48, high 49
`define PKT_RESET       32'h0031_302f
// timing
`define CLK_HZ          50000000
`define FS_HZ           48000
`define SOF_PERIOD_NS   1000000
`define CLK_PERIOD_NS   20
`define SOF_CYCLES      (`SOF_PERIOD_NS / `CLK_PERIOD_NS)
// each carry toggles the bit clock, so carries run at 2*64*48 kHz: 2^24*6144000/50e6
`define BCLK_STEP_NOM   24'h1f7510
`define TRIM_STEP       24'h000040
`define SOF_AVG_LOG2    4
// fifo
`define FIFO_AW         6
`define FIFO_DEPTH      64
`endif

// ---- sample_fifo.v ----
// sample_fifo: 32-bit sample fifo with fill level
// assumes one clock; a push when full or a pop when empty is ignored
`timescale 1ns/1ps
`default_nettype none
`include "audio_rate_defs.vh"
module sample_fifo (
   input  wire                ref_clk,
   input  wire                nrst,
   input  wire                flush,
   input  wire                push,
   input  wire [31:0]         wdata,
   input  wire                pop,
   output wire [31:0]         rdata,
   output reg  [`FIFO_AW:0]   level_q,
   output wire                full,
   output wire                empty
);
   reg [31:0]         mem [0:`FIFO_DEPTH-1];
   reg [`FIFO_AW-1:0] wr_q;
   reg [`FIFO_AW-1:0] rd_q;
   wire               do_push = push & ~full;
   wire               do_pop  = pop & ~empty;

   assign full  = (level_q == `FIFO_DEPTH);
   assign empty = (level_q == {(`FIFO_AW+1){1'b0}});
   assign rdata = mem[rd_q];

   always @(posedge ref_clk) begin
      if (do_push)
         mem[wr_q] <= wdata;
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_q    <= {`FIFO_AW{1'b0}};
         rd_q    <= {`FIFO_AW{1'b0}};
         level_q <= {(`FIFO_AW+1){1'b0}};
      end else if (flush) begin
         wr_q    <= {`FIFO_AW{1'b0}};
         rd_q    <= {`FIFO_AW{1'b0}};
         level_q <= {(`FIFO_AW+1){1'b0}};
      end else begin
         if (do_push)
            wr_q <= wr_q + 1'b1;
         if (do_pop)
            rd_q <= rd_q + 1'b1;
         if (do_push && !do_pop)
            level_q <= level_q + 1'b1;
         else if (do_pop && !do_push)
            level_q <= level_q - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- audio_rate_ctrl.v ----
// audio_rate_ctrl: serial audio port with fifo water-mark rate control
// assumes apb master on ref_clk; codec is slave to our bit and word clocks
// How it works
// - port has serial in, serial out, bit, word, master clocks, mic detect
// - serial out only used for playback, serial in only for capture
// - asynchronous, synchronous and adaptive rate matching modes supported
// - async capture keeps sampling clock at nominal 48 kHz only while playback is async too
// - async capture writes codec samples into input fifo with water marks
// - per-frame packet size picked from three size registers by fill level
// - fill above high mark sends high packet size
// - fill below low mark sends low packet size
// - adaptive playback starts at 48 kHz, host data goes to output fifo
// - adaptive: output fill above high mark speeds up sampling clock
// - adaptive: fill between marks leaves sampling clock unchanged
// - adaptive: output fill below low mark slows sampling clock
// - synchronous mode locks audio clock to host frame markers
// - frame intervals averaged over long period to remove jitter
// - synchronous mode derives sampling clock from averaged frame period
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "audio_rate_defs.vh"
module audio_rate_ctrl (
   input  wire        ref_clk,
   input  wire        nrst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        sof_pulse,
   input  wire        audio_serial_in,
   output reg         audio_serial_out,
   output reg         audio_bit_clock,
   output reg         audio_word_clock,
   output reg         audio_master_clock,
   input  wire        microphone_plug_detect,
   output reg  [15:0] in_packet_size,
   output reg         in_packet_valid
);
   reg  [31:0]        ctrl_q;
   reg  [15:0]        fifo_low_water_mark;
   reg  [15:0]        fifo_high_water_mark;
   reg  [15:0]        low_packet_size;
   reg  [15:0]        nominal_packet_size;
   reg  [15:0]        high_packet_size;
   reg  [23:0]        step_q;
   reg  [23:0]        phase_q;
   reg  [5:0]         bit_cnt_q;
   reg  [31:0]        rx_shift_q;
   reg  [31:0]        tx_shift_q;
   reg  [31:0]        sof_cnt_q;
   reg  [31:0]        sof_acc_q;
   reg  [31:0]        sof_avg_q;
   reg  [`SOF_AVG_LOG2-1:0] sof_n_q;
   reg                sof_valid_q;
   reg                mic_q;
   reg  [31:0]        out_wdata_q;
   reg                out_push_q;
   wire               enable    = ctrl_q[`CTRL_EN_BIT];
   wire [1:0]         in_mode   = ctrl_q[`CTRL_IN_MODE];
   wire [1:0]         out_mode  = ctrl_q[`CTRL_OUT_MODE];
   wire               apb_setup = psel & ~penable;
   wire               apb_wr    = psel & penable & pready & pwrite;
   wire [6:0]         in_level;
   wire [6:0]         out_level;
   wire               in_full;
   wire               in_empty;
   wire               out_full;
   wire               out_empty;
   wire [31:0]        out_rdata;
   wire [31:0]        in_rdata;
   wire [24:0]        phase_sum = {1'b0, phase_q} + {1'b0, step_q};
   wire               bclk_tick = phase_sum[24] & enable;
   wire               bclk_fall = bclk_tick & audio_bit_clock;
   wire               bclk_rise = bclk_tick & ~audio_bit_clock;
   wire               word_end  = bclk_fall & (bit_cnt_q == 6'h3f);
   wire               in_pop    = psel & penable & pready & ~pwrite
                                  & (paddr == `REG_FIFO);
   wire               sof_wrap  = sof_valid_q
                                  & (sof_n_q == {`SOF_AVG_LOG2{1'b1}});
   reg                unmapped;
   reg  [31:0]        rd_mux;
   reg  [23:0]        sync_step;

   sample_fifo in_fifo (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .flush   (~enable),
      .push    (word_end & ~in_full),
      .wdata   (rx_shift_q),
      .pop     (in_pop),
      .rdata   (in_rdata),
      .level_q (in_level),
      .full    (in_full),
      .empty   (in_empty)
   );

   // playback fifo fed from host writes
   sample_fifo out_fifo (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .flush   (~enable),
      .push    (out_push_q),
      .wdata   (out_wdata_q),
      .pop     (word_end),
      .rdata   (out_rdata),
      .level_q (out_level),
      .full    (out_full),
      .empty   (out_empty)
   );

   always @* begin
      unmapped = 1'b0;
      rd_mux   = 32'h0000_0000;
      case (paddr)
         `REG_CTRL:    rd_mux = ctrl_q;
         `REG_WATER:   rd_mux = {fifo_high_water_mark, fifo_low_water_mark};
         `REG_PKT:     rd_mux = {8'h00, high_packet_size[7:0],
                                 nominal_packet_size[7:0], low_packet_size[7:0]};
         `REG_STATUS:  rd_mux = {9'h000, out_level, 1'b0, in_level, 4'h0,
                                 sof_valid_q, out_full, in_empty, mic_q};
         `REG_SOF_AVG: rd_mux = sof_avg_q;
         `REG_RATE:    rd_mux = {8'h00, step_q};
         `REG_FIFO:    rd_mux = in_rdata;
         default:      unmapped = 1'b1;
      endcase
   end

   // apb slave: no wait states, answer registered
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup & unmapped;
         if (apb_setup && !pwrite)
            prdata <= rd_mux;
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q               <= `CTRL_RESET;
         fifo_low_water_mark  <= 16'h0008;
         fifo_high_water_mark <= 16'h0018;
         low_packet_size      <= 16'h002f;
         nominal_packet_size  <= 16'h0030;
         high_packet_size     <= 16'h0031;
         out_push_q           <= 1'b0;
         out_wdata_q          <= 32'h0000_0000;
      end else begin
         out_push_q <= apb_wr & (paddr == `REG_FIFO) & ~out_full;
         if (apb_wr) begin
            case (paddr)
               `REG_CTRL: ctrl_q <= {27'h0000000, pwdata[4:0]};
               `REG_WATER: begin
                  fifo_low_water_mark  <= pwdata[15:0];
                  fifo_high_water_mark <= pwdata[31:16];
               end
               `REG_PKT: begin
                  low_packet_size     <= {8'h00, pwdata[7:0]};
                  nominal_packet_size <= {8'h00, pwdata[15:8]};
                  high_packet_size    <= {8'h00, pwdata[23:16]};
               end
               `REG_FIFO: out_wdata_q <= pwdata;
               default: ;
            endcase
         end
      end
   end

   // count frame intervals, average over 16 frames
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sof_cnt_q   <= 32'h0000_0000;
         sof_acc_q   <= 32'h0000_0000;
         sof_avg_q   <= `SOF_CYCLES;
         sof_n_q     <= {`SOF_AVG_LOG2{1'b0}};
         sof_valid_q <= 1'b0;
      end else if (sof_pulse) begin
         sof_cnt_q   <= 32'h0000_0001;
         sof_valid_q <= 1'b1;
         if (sof_valid_q) begin
            sof_n_q <= sof_n_q + 1'b1;
            if (sof_wrap) begin
               sof_avg_q <= (sof_acc_q + sof_cnt_q) >> `SOF_AVG_LOG2;
               sof_acc_q <= 32'h0000_0000;
            end else begin
               sof_acc_q <= sof_acc_q + sof_cnt_q;
            end
         end
      end else if (sof_cnt_q != 32'hffff_ffff) begin
         sof_cnt_q <= sof_cnt_q + 1'b1;
      end
   end

   // move nominal step by one TRIM_STEP when the averaged frame is off by more than 8 cycles
   always @* begin
      sync_step = `BCLK_STEP_NOM;
      if (sof_avg_q > (`SOF_CYCLES + 32'd8))
         sync_step = `BCLK_STEP_NOM - `TRIM_STEP;
      else if (sof_avg_q < (`SOF_CYCLES - 32'd8))
         sync_step = `BCLK_STEP_NOM + `TRIM_STEP;
   end

   // sampling clock step: adaptive updates once per frame, sync follows the 16-frame average
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         step_q <= `BCLK_STEP_NOM;
      end else if (!enable) begin
         step_q <= `BCLK_STEP_NOM;
      end else if (out_mode == `MODE_SYNC || in_mode == `MODE_SYNC) begin
         step_q <= sync_step;
      end else if (out_mode == `MODE_ADAPT && sof_pulse) begin
         if ({9'h000, out_level} > fifo_high_water_mark)
            step_q <= step_q + `TRIM_STEP;
         else if ({9'h000, out_level} < fifo_low_water_mark)
            step_q <= step_q - `TRIM_STEP;
      end else if (out_mode != `MODE_ADAPT) begin
         step_q <= `BCLK_STEP_NOM;
      end
   end

   // packet size chosen on each frame marker
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         in_packet_size  <= 16'h0000;
         in_packet_valid <= 1'b0;
      end else begin
         in_packet_valid <= sof_pulse & enable;
         if (sof_pulse) begin
            if ({9'h000, in_level} > fifo_high_water_mark)
               in_packet_size <= high_packet_size;
            else if ({9'h000, in_level} < fifo_low_water_mark)
               in_packet_size <= low_packet_size;
            else
               in_packet_size <= nominal_packet_size;
         end
      end
   end

   // clocks: bit clock 64 per word, master clock from phase bit 22
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         phase_q            <= 24'h000000;
         audio_bit_clock    <= 1'b0;
         audio_word_clock   <= 1'b0;
         audio_master_clock <= 1'b0;
         bit_cnt_q          <= 6'h00;
         mic_q              <= 1'b0;
      end else begin
         mic_q              <= microphone_plug_detect;
         phase_q            <= phase_sum[23:0];
         audio_master_clock <= phase_q[22] & enable;
         if (bclk_tick)
            audio_bit_clock <= ~audio_bit_clock;
         if (bclk_fall) begin
            bit_cnt_q        <= bit_cnt_q + 1'b1;
            audio_word_clock <= bit_cnt_q[5] ^ (bit_cnt_q[4:0] == 5'h1f);
         end
      end
   end

   // capture on rising edge of bit clock, playback shifts on falling
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rx_shift_q       <= 32'h0000_0000;
         tx_shift_q       <= 32'h0000_0000;
         audio_serial_out <= 1'b0;
      end else begin
         if (bclk_rise && bit_cnt_q[4:0] < 5'h10)
            rx_shift_q <= {rx_shift_q[30:0], audio_serial_in};
         if (word_end)
            tx_shift_q <= out_empty ? 32'h0000_0000 : out_rdata;
         else if (bclk_fall && bit_cnt_q[4:0] == 5'h1f)
            tx_shift_q <= {tx_shift_q[15:0], 16'h0000};
         else if (bclk_fall)
            tx_shift_q <= {tx_shift_q[30:0], 1'b0};
         if (bclk_fall)
            audio_serial_out <= (out_mode == `MODE_ASYNC) ? 1'b0
                                : tx_shift_q[31];
      end
   end
endmodule
`default_nettype wire

// ---- audio_rate_ctrl_chk.sv ----
// checker: apb answer timing, packet pulse and word clock hold of audio_rate_ctrl
// assumes it is bound onto the audio_rate_ctrl ports
`timescale 1ns/1ps
`default_nettype none
module audio_rate_ctrl_chk (
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       sof_pulse,
   input wire logic       in_packet_valid,
   input wire logic       audio_word_clock
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   a_err_unmapped: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
      else $error("no error on unmapped address");
   a_ok_mapped: assert property (psel && !penable && paddr <= 8'h18 && paddr[1:0] == 2'h0
      |=> !pslverr)
      else $error("error on mapped address");
   a_pkt_after_sof: assert property (in_packet_valid |-> $past(sof_pulse))
      else $error("packet size without frame marker");
   a_pkt_one_pulse: assert property (in_packet_valid |=> !in_packet_valid)
      else $error("packet valid longer than one cycle");
   // a word is 64 bit clocks, so the word clock can never flip within 8 cycles
   a_word_clock_hold: assert property ($changed(audio_word_clock)
      |=> $stable(audio_word_clock) [*8])
      else $error("word clock toggles too fast");
endmodule
bind audio_rate_ctrl audio_rate_ctrl_chk audio_rate_ctrl_chk_inst (
   .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .sof_pulse(sof_pulse),
   .in_packet_valid(in_packet_valid), .audio_word_clock(audio_word_clock));
`default_nettype wire

// ---- codec_model.sv ----
// codec_model: capture source and playback sink on the serial side
// assumes the block drives bit and word clocks; the codec is a clock slave
`timescale 1ns/1ps
`default_nettype none
module codec_model (
   input  wire logic audio_bit_clock,
   input  wire logic audio_serial_out,
   output wire logic audio_serial_in
);
   logic [15:0] lfsr_q = 16'hace1;
   logic [31:0] play_q = 32'h0;
   // new bit every clock so a stuck sampler is not hidden
   always @(negedge audio_bit_clock) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
   end
   assign audio_serial_in = lfsr_q[0];
   always @(posedge audio_bit_clock) begin
      play_q <= {play_q[30:0], audio_serial_out};
   end
endmodule
`default_nettype wire

// ---- audio_rate_ctrl_tb_top.sv ----
// audio_rate_ctrl_tb_top: apb driven self-checking bench with a codec model
// assumes audio_rate_defs.vh constants and a 50 MHz ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "audio_rate_defs.vh"
module audio_rate_ctrl_tb_top;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        sof_pulse = 1'b0;
   logic        mic = 1'b0;
   wire  [31:0] prdata;
   wire  [15:0] pkt_sz;
   wire         pready, pslverr, sdi, sdo, bclk, wclk, mclk, pkt_v;
   logic [31:0] rs = 32'h6ceb1ac5;
   logic [31:0] rd, pk, ex_rate;
   logic        er;
   int          error_cnt = 0;
   int          n_checks = 0;
   audio_rate_ctrl audio_rate_ctrl_inst (
      .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sof_pulse(sof_pulse), .audio_serial_in(sdi), .audio_serial_out(sdo),
      .audio_bit_clock(bclk), .audio_word_clock(wclk), .audio_master_clock(mclk),
      .microphone_plug_detect(mic), .in_packet_size(pkt_sz), .in_packet_valid(pkt_v));
   codec_model codec_model_inst (.audio_bit_clock(bclk), .audio_serial_out(sdo),
      .audio_serial_in(sdi));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // request held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // exp below zero skips the packet size compare
   task sof(input int exp);
      @(posedge ref_clk);
      sof_pulse <= 1'b1;
      @(posedge ref_clk);
      sof_pulse <= 1'b0;
      @(negedge ref_clk);
      if (exp >= 0) begin
         chk(pkt_v, 1'b1);
         chk(pkt_sz, exp[15:0]);
      end
   endtask
   task end_sim();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk);
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      pk = xs();
      mic <= rs[0];
      apb(0, `REG_CTRL, 0);
      chk(rd, `CTRL_RESET);
      apb(0, `REG_WATER, 0);
      chk(rd, `WATER_RESET);
      apb(0, `REG_PKT, 0);
      chk(rd, `PKT_RESET);
      apb(0, `REG_RATE, 0);
      chk(rd, {8'h0, `BCLK_STEP_NOM});
      apb(0, `REG_STATUS, 0);
      chk(rd[0], mic);
      apb(0, 8'h40, 0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      // disabling flushes the fifos, so the capture level starts at zero
      apb(1, `REG_CTRL, 32'h0);
      pk = xs() & 32'h00ff_ffff;
      apb(1, `REG_PKT, pk);
      apb(1, `REG_WATER, 32'h0002_0001);
      apb(1, `REG_CTRL, 32'h1);
      sof(pk[7:0]);
      apb(1, `REG_WATER, 32'h0);
      sof(pk[15:8]);
      repeat (5000) @(posedge ref_clk);
      sof(pk[23:16]);
      apb(0, `REG_RATE, 0);
      chk(rd, {8'h0, `BCLK_STEP_NOM});
      chk(sdo, 1'b0);
      apb(0, `REG_STATUS, 0);
      chk(rd[1], 1'b0);
      apb(1, `REG_CTRL, 32'h0);
      apb(1, `REG_WATER, 32'h0003_0000);
      apb(1, `REG_CTRL, 32'h11);
      ex_rate = {8'h0, `BCLK_STEP_NOM};
      sof(-1);
      apb(0, `REG_RATE, 0);
      chk(rd, ex_rate);
      apb(1, `REG_WATER, 32'h0003_0001);
      sof(-1);
      ex_rate = ex_rate - `TRIM_STEP;
      apb(0, `REG_RATE, 0);
      chk(rd, ex_rate);
      repeat (8) apb(1, `REG_FIFO, xs());
      sof(-1);
      ex_rate = ex_rate + `TRIM_STEP;
      apb(0, `REG_RATE, 0);
      chk(rd, ex_rate);
      apb(1, `REG_CTRL, 32'h0);
      apb(1, `REG_CTRL, 32'h0b);
      // markers every 2000 cycles; 32 of them so one 16-frame window holds no stale interval
      repeat (32) begin
         sof(-1);
         repeat (1998) @(posedge ref_clk);
      end
      apb(0, `REG_SOF_AVG, 0);
      chk(rd, 32'd2000);
      apb(0, `REG_RATE, 0);
      chk(rd, {8'h0, `BCLK_STEP_NOM + `TRIM_STEP});
      end_sim();
   end
endmodule
`default_nettype wire
